// ### keypad_pin_interrupt_pkg.sv
// constants and types shared by the keypad pin interrupt block
package keypad_pin_interrupt_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int REG_WIDTH = 8;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] PIN_ENABLE_OFFSET = 12'h004;
  localparam logic [11:0] POLARITY_SELECT_OFFSET = 12'h008;

  // ****************************************************************
  // status and control field positions
  // ****************************************************************
  localparam int DETECTION_MODE_BIT = 0;
  localparam int REQUEST_ENABLE_BIT = 1;
  localparam int FLAG_ACKNOWLEDGE_BIT = 2;
  localparam int DETECT_FLAG_BIT = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic [7:0] POLARITY_SELECT_RESET = 8'h00;
  localparam logic DETECTION_MODE_RESET = 1'b0;
  localparam logic REQUEST_ENABLE_RESET = 1'b0;
  localparam logic DETECT_FLAG_RESET = 1'b0;

  // ****************************************************************
  // register selector
  // ****************************************************************
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_STATUS_CONTROL,
    SEL_PIN_ENABLE,
    SEL_POLARITY_SELECT
  } reg_sel_t;

endpackage

// ### keypad_pin_sync.sv
// two flip-flop synchroniser for the keypad input pins
`timescale 1ns/10ps
`default_nettype none

module keypad_pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and synchronised copy
  input wire logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] pin_async,
  output logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] pin_sync
);
  import keypad_pin_interrupt_pkg::*;

  logic [PIN_COUNT-1:0] stage1_q;
  logic [PIN_COUNT-1:0] stage2_q;

  // ****************************************************************
  // two stages for all pins
  // ****************************************************************
  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pin_async;
      stage2_q <= stage1_q;
    end
  end

  assign pin_sync = stage2_q;

endmodule

`default_nettype wire

// ### keypad_pin_detect.sv
// per-pin assertion and shared edge/level detection for the keypad block
`timescale 1ns/10ps
`default_nettype none

module keypad_pin_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // synchronous return to reset state
  input wire logic soft_clear,
  // synchronised pins and configuration
  input wire logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] pin_sync,
  input wire logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] pin_enable,
  input wire logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] pin_polarity,
  input wire logic detection_mode,
  // results
  output logic detect_event,
  output logic any_asserted
);
  import keypad_pin_interrupt_pkg::*;

  logic [PIN_COUNT-1:0] asserted;
  logic [PIN_COUNT-1:0] asserted_prev_q;
  logic armed_q;
  logic edge_seen;

  // ****************************************************************
  // assertion per pin
  // ****************************************************************
  // enable and polarity
  assign asserted = pin_enable & ~(pin_sync ^ pin_polarity);
  assign any_asserted = |asserted;

  assign edge_seen = |(asserted & ~asserted_prev_q);

  assign detect_event = (armed_q & edge_seen) | (detection_mode & any_asserted);

  // previous-cycle view of each pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asserted_prev_q <= '0;
    end else if (soft_clear) begin
      asserted_prev_q <= '0;
    end else begin
      asserted_prev_q <= asserted;
    end
  end

  // ****************************************************************
  // rearm after all pins release
  // ****************************************************************
  // wait for full release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (soft_clear) begin
      armed_q <= 1'b0;
    end else if (!any_asserted) begin
      armed_q <= 1'b1;
    end else if (edge_seen) begin
      armed_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### keypad_pin_interrupt.sv
// keypad pin interrupt block with APB register access
// ****************************************************************
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none

module keypad_pin_interrupt (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [keypad_pin_interrupt_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [keypad_pin_interrupt_pkg::DATA_WIDTH-1:0] pwdata,
  output logic [keypad_pin_interrupt_pkg::DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // keypad pins
  input wire logic [keypad_pin_interrupt_pkg::PIN_COUNT-1:0] interrupt_input_pin,
  // power mode controls
  input wire logic light_stop,
  input wire logic deep_stop,
  // cpu request and wakeup
  output logic irq,
  output logic wake_request
);
  import keypad_pin_interrupt_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [PIN_COUNT-1:0] pin_enable_bit_q;
  logic [PIN_COUNT-1:0] pin_polarity_bit_q;
  logic detection_mode_q;
  logic request_enable_q;
  logic detect_flag_q;
  logic [DATA_WIDTH-1:0] prdata_q;
  logic [PIN_COUNT-1:0] pin_sync;
  logic detect_event;
  logic any_asserted;
  logic setup_phase;
  logic write_access;
  reg_sel_t sel;
  logic ack_write;
  logic flag_clear;
  logic [PIN_COUNT-1:0] raw_asserted;
  logic raw_any;
  // next values of the registers
  logic [PIN_COUNT-1:0] pin_enable_bit_d;
  logic [PIN_COUNT-1:0] pin_polarity_bit_d;
  logic detection_mode_d;
  logic request_enable_d;
  logic detect_flag_d;
  logic [DATA_WIDTH-1:0] prdata_d;
  // per-register write strobes
  logic wr_status_control;
  logic wr_pin_enable;
  logic wr_polarity_select;
  // power mode terms
  logic hold_in_reset;
  logic light_stop_wake;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic reg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
    reg_sel_t result;
    result = SEL_NONE;
    case (addr)
      STATUS_CONTROL_OFFSET: result = SEL_STATUS_CONTROL;
      PIN_ENABLE_OFFSET: result = SEL_PIN_ENABLE;
      POLARITY_SELECT_OFFSET: result = SEL_POLARITY_SELECT;
      default: result = SEL_NONE;
    endcase
    return result;
  endfunction

  // bus phases, zero wait states
  assign sel = decode(paddr);
  assign setup_phase = psel & ~penable;
  assign write_access = psel & penable & pwrite;
  assign pready = 1'b1;
  // error on unmapped offsets
  assign pslverr = psel & penable & (sel == SEL_NONE);

  // ****************************************************************
  // per-register write strobes
  // ****************************************************************
  // one strobe per register, access phase only
  assign wr_status_control = write_access & (sel == SEL_STATUS_CONTROL);
  assign wr_pin_enable = write_access & (sel == SEL_PIN_ENABLE);
  assign wr_polarity_select = write_access & (sel == SEL_POLARITY_SELECT);

  // ****************************************************************
  // power modes
  // ****************************************************************
  // deep stop holds every register except the synchroniser and read data at reset
  assign hold_in_reset = deep_stop;

  // ****************************************************************
  // input synchroniser and detector
  // ****************************************************************
  // two flip-flops on every pin
  keypad_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(interrupt_input_pin),
    .pin_sync(pin_sync)
  );

  keypad_pin_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .soft_clear(hold_in_reset),
    .pin_sync(pin_sync),
    .pin_enable(pin_enable_bit_q),
    .pin_polarity(pin_polarity_bit_q),
    .detection_mode(detection_mode_q),
    .detect_event(detect_event),
    .any_asserted(any_asserted)
  );

  // ****************************************************************
  // pin enable register
  // ****************************************************************
  // next pin enables
  always_comb begin
    pin_enable_bit_d = pin_enable_bit_q;
    if (hold_in_reset) begin
      pin_enable_bit_d = PIN_ENABLE_RESET;
    end else if (wr_pin_enable) begin
      pin_enable_bit_d = pwdata[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_enable_bit_q <= PIN_ENABLE_RESET;
    end else begin
      pin_enable_bit_q <= pin_enable_bit_d;
    end
  end

  // ****************************************************************
  // polarity select register
  // ****************************************************************
  // next polarity selects
  always_comb begin
    pin_polarity_bit_d = pin_polarity_bit_q;
    if (hold_in_reset) begin
      pin_polarity_bit_d = POLARITY_SELECT_RESET;
    end else if (wr_polarity_select) begin
      pin_polarity_bit_d = pwdata[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_polarity_bit_q <= POLARITY_SELECT_RESET;
    end else begin
      pin_polarity_bit_q <= pin_polarity_bit_d;
    end
  end

  // ****************************************************************
  // detection mode bit
  // ****************************************************************
  // next detection mode
  always_comb begin
    detection_mode_d = detection_mode_q;
    if (hold_in_reset) begin
      detection_mode_d = DETECTION_MODE_RESET;
    end else if (wr_status_control) begin
      detection_mode_d = pwdata[DETECTION_MODE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detection_mode_q <= DETECTION_MODE_RESET;
    end else begin
      detection_mode_q <= detection_mode_d;
    end
  end

  // ****************************************************************
  // request enable bit
  // ****************************************************************
  // next request enable
  always_comb begin
    request_enable_d = request_enable_q;
    if (hold_in_reset) begin
      request_enable_d = REQUEST_ENABLE_RESET;
    end else if (wr_status_control) begin
      request_enable_d = pwdata[REQUEST_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_enable_q <= REQUEST_ENABLE_RESET;
    end else begin
      request_enable_q <= request_enable_d;
    end
  end

  // ****************************************************************
  // shared detection flag
  // ****************************************************************
  // acknowledge write
  assign ack_write = wr_status_control & pwdata[FLAG_ACKNOWLEDGE_BIT];
  assign flag_clear = ack_write & (~detection_mode_q | ~any_asserted);

  always_comb begin
    detect_flag_d = detect_flag_q;
    if (hold_in_reset) begin
      detect_flag_d = DETECT_FLAG_RESET;
    end else if (detect_event) begin
      detect_flag_d = 1'b1;
    end else if (flag_clear) begin
      detect_flag_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_flag_q <= DETECT_FLAG_RESET;
    end else begin
      detect_flag_q <= detect_flag_d;
    end
  end

  // ****************************************************************
  // cpu request and wakeup
  // ****************************************************************
  // gated request
  assign irq = detect_flag_q & request_enable_q;

  // clockless path for light stop, no synchroniser on purpose
  assign raw_asserted = pin_enable_bit_q & ~(interrupt_input_pin ^ pin_polarity_bit_q);
  assign raw_any = |raw_asserted;
  assign light_stop_wake = light_stop & request_enable_q & raw_any;
  // wake through the request in wait
  assign wake_request = irq | light_stop_wake;

  // ****************************************************************
  // read data
  // ****************************************************************
  // upper bits zero, acknowledge reads zero
  always_comb begin
    prdata_d = prdata_q;
    if (setup_phase) begin
      prdata_d = '0;
      case (sel)
        SEL_STATUS_CONTROL: begin
          prdata_d[DETECT_FLAG_BIT] = detect_flag_q;
          prdata_d[REQUEST_ENABLE_BIT] = request_enable_q;
          prdata_d[DETECTION_MODE_BIT] = detection_mode_q;
        end
        SEL_PIN_ENABLE: prdata_d[PIN_COUNT-1:0] = pin_enable_bit_q;
        SEL_POLARITY_SELECT: prdata_d[PIN_COUNT-1:0] = pin_polarity_bit_q;
        default: ;
      endcase
    end
  end

  // read data held from the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule

`default_nettype wire

// ### keypad_pin_interrupt_chk.sv
// assertion checker for the keypad pin interrupt block
`timescale 1ns/10ps
`default_nettype none
module keypad_pin_interrupt_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins, power modes, requests
  input wire logic [7:0] interrupt_input_pin,
  input wire logic light_stop,
  input wire logic deep_stop,
  input wire logic irq,
  input wire logic wake_request
);
  import keypad_pin_interrupt_pkg::*;
  logic [7:0] pe_q;
  logic [1:0] ctl_q;
  logic acc;
  logic wr_sc;
  // access phase and status writes
  assign acc = psel && penable;
  assign wr_sc = acc && pwrite && paddr == STATUS_CONTROL_OFFSET;
  // shadow of the pin enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pe_q <= 8'h00;
    else if (deep_stop) pe_q <= 8'h00;
    else if (acc && pwrite && paddr == PIN_ENABLE_OFFSET) pe_q <= pwdata[7:0];
  end
  // shadow of request enable and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 2'h0;
    else if (deep_stop) ctl_q <= 2'h0;
    else if (wr_sc) ctl_q <= pwdata[1:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_sc;
    acc && !pwrite && paddr == STATUS_CONTROL_OFFSET;
  endsequence
  AST_EN_READ: assert property (
    acc && !pwrite && paddr == PIN_ENABLE_OFFSET |-> prdata[7:0] == pe_q) else $error("enable");
  AST_CTL_READ: assert property (
    rd_sc |-> prdata[1:0] == ctl_q) else $error("control bits");
  AST_ACK_ZERO: assert property (
    rd_sc |-> !prdata[FLAG_ACKNOWLEDGE_BIT]) else $error("ack reads one");
  AST_HIGH_ZERO: assert property (
    rd_sc |-> prdata[7:4] == 4'h0) else $error("upper bits set");
  AST_IRQ_GATE: assert property (
    irq |-> ctl_q[1]) else $error("irq without enable");
  AST_FLAG_HOLD: assert property (
    irq && !wr_sc && !deep_stop |=> irq) else $error("flag lost");
  AST_DEEP: assert property (
    deep_stop |=> !irq) else $error("irq after deep stop");
  AST_WAKE: assert property (
    irq |-> wake_request) else $error("no wake");
  AST_UNMAPPED: assert property (
    acc && paddr > 12'h008 |-> pslverr && pready) else $error("no error");
endmodule
bind keypad_pin_interrupt keypad_pin_interrupt_chk keypad_pin_interrupt_chk_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .interrupt_input_pin,
  .light_stop, .deep_stop, .irq, .wake_request);
`default_nettype wire

// ### keypad_matrix.sv
// switch matrix model driving the keypad pins
`timescale 1ns/10ps
`default_nettype none
module keypad_matrix (
  // key state and pull direction
  input wire logic [7:0] pressed,
  input wire logic [7:0] pull_down,
  // pins towards the block
  output logic [7:0] pin
);
  // idle pins rest at the pull level, pressed ones at the other
  assign pin = ~(pressed ^ pull_down);
endmodule
`default_nettype wire

// ### tb.sv
// self-checking testbench for the keypad pin interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import keypad_pin_interrupt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic rerr;
  logic irq;
  logic wake_request;
  logic light_stop = 1'b0;
  logic deep_stop = 1'b0;
  logic [7:0] pressed = 8'h00;
  logic [7:0] pull_down = 8'h00;
  logic [7:0] pin;
  int n_errors = 0;
  int checks_done = 0;
  // clock generator
  always #12.5 pclk = ~pclk;
  keypad_matrix keypad_matrix_i (.pressed, .pull_down, .pin);
  keypad_pin_interrupt keypad_pin_interrupt_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .interrupt_input_pin(pin), .light_stop,
    .deep_stop, .irq, .wake_request);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp(rdata, {24'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_reset;
    rd(STATUS_CONTROL_OFFSET, 8'h00);
    rd(PIN_ENABLE_OFFSET, 8'h00);
    rd(POLARITY_SELECT_OFFSET, 8'h00);
    rd(12'h00c, 8'h00);
    cmp(rerr, 1);
    cmp(irq, 0);
  endtask
  task automatic t_edge;
    pull_down <= 8'h04;
    wr(POLARITY_SELECT_OFFSET, 8'h04);
    wr(PIN_ENABLE_OFFSET, 8'h05);
    wr(STATUS_CONTROL_OFFSET, 8'h04);
    pressed <= 8'h02;
    cyc(5);
    rd(STATUS_CONTROL_OFFSET, 8'h00);
    pressed <= 8'h00;
    wr(STATUS_CONTROL_OFFSET, 8'h08);
    rd(STATUS_CONTROL_OFFSET, 8'h00);
    pressed <= 8'h01;
    cyc(5);
    cmp(irq, 0);
    rd(STATUS_CONTROL_OFFSET, 8'h08);
    wr(STATUS_CONTROL_OFFSET, 8'h04);
    pressed <= 8'h05;
    cyc(5);
    rd(STATUS_CONTROL_OFFSET, 8'h00);
    pressed <= 8'h00;
    cyc(3);
    pressed <= 8'h04;
    cyc(5);
    rd(STATUS_CONTROL_OFFSET, 8'h08);
    wr(STATUS_CONTROL_OFFSET, 8'h0a);
    cmp(irq, 1);
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    cmp(irq, 0);
    rd(STATUS_CONTROL_OFFSET, 8'h02);
    pressed <= 8'h00;
  endtask
  task automatic t_level;
    wr(STATUS_CONTROL_OFFSET, 8'h01);
    pressed <= 8'h01;
    cyc(5);
    wr(STATUS_CONTROL_OFFSET, 8'h05);
    rd(STATUS_CONTROL_OFFSET, 8'h09);
    pressed <= 8'h00;
    cyc(3);
    wr(STATUS_CONTROL_OFFSET, 8'h05);
    rd(STATUS_CONTROL_OFFSET, 8'h01);
  endtask
  task automatic t_stop;
    wr(STATUS_CONTROL_OFFSET, 8'h02);
    light_stop <= 1'b1;
    pressed <= 8'h01;
    cyc(1);
    cmp(wake_request, 1);
    cyc(5);
    cmp(irq, 1);
    light_stop <= 1'b0;
    deep_stop <= 1'b1;
    cyc(2);
    deep_stop <= 1'b0;
    cyc(1);
    cmp(irq, 0);
    rd(PIN_ENABLE_OFFSET, 8'h00);
    rd(STATUS_CONTROL_OFFSET, 8'h00);
    pressed <= 8'h00;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    t_reset;
    t_edge;
    t_level;
    t_stop;
    end_sim;
  end
  // watchdog
  initial begin
    #500000;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
